// *** include/dag_pkg.sv ***
package dag_pkg;
    // Register byte offsets on the bus.
    localparam logic [7:0]  OFF_AREG0  = 8'h00;
    localparam logic [7:0]  OFF_AREG7  = 8'h1c;
    localparam logic [7:0]  OFF_CMD    = 8'h20;
    localparam logic [7:0]  OFF_OFFSET = 8'h24;
    localparam logic [7:0]  OFF_SRC    = 8'h28;
    localparam logic [7:0]  OFF_RESULT = 8'h2c;
    localparam logic [7:0]  OFF_STATUS = 8'h30;
    localparam logic [7:0]  OFF_APTR   = 8'h34;
    // Memory geometry and special address registers.
    localparam int          RAM_WORDS  = 640;
    localparam int          RAM_AW     = 10;
    localparam logic [2:0]  IDX_REG    = 3'h5;
    localparam logic [2:0]  PAGE_REG   = 3'h6;
    localparam logic [15:0] STEP_WORD  = 16'h0002;
    localparam logic [15:0] STEP_BYTE  = 16'h0001;
    localparam logic [7:0]  NARROW_PORT = 8'h08;
    localparam logic [4:0]  AP_PARTNER = 5'h10;
    // Command word field positions.
    localparam int          CMD_OP_LSB   = 0;
    localparam int          CMD_MODE_LSB = 4;
    localparam int          CMD_REG_LSB  = 7;
    localparam int          CMD_FLD_LSB  = 10;
    localparam int          CMD_BYTE_BIT = 17;
    localparam int          CMD_AP_LSB   = 18;
    localparam int          CMD_TF_BIT   = 20;
    localparam int          CMD_PORT_LSB = 24;
    localparam logic [1:0]  AP_INC = 2'h1;
    localparam logic [1:0]  AP_DEC = 2'h2;
    // Status word bit positions.
    localparam int          ST_TAG  = 0;
    localparam int          ST_TF1  = 1;
    localparam int          ST_TF2  = 2;
    localparam int          ST_ZERO = 3;
    localparam int          ST_SIGN = 4;
    // Values after reset.
    localparam logic [15:0] AREG_RST   = 16'h0000;
    localparam logic [4:0]  STATUS_RST = 5'h00;
    localparam logic [4:0]  AP_RST     = 5'h00;

    typedef enum logic [3:0] {
        OP_NOP, OP_LOAD, OP_STORE, OP_PIN, OP_POUT, OP_TSET, OP_TCLR,
        OP_FSET, OP_FCLR, OP_FMOV, OP_FAND, OP_FOR, OP_FXOR
    } dag_op_t;

    typedef enum logic [2:0] {
        M_IND, M_INC, M_DEC, M_ADDX, M_IDXREL, M_PAGEREL, M_LONGREL, M_DIRECT
    } dag_mode_t;
endpackage : dag_pkg

// *** verilog/dag_agu.sv ***
`timescale 1ns/1ps
`default_nettype none
module dag_agu (
    // Mode and operands
    input  wire dag_pkg::dag_mode_t mode,
    input  wire logic               byte_op,
    input  wire logic [15:0]        base,
    input  wire logic [15:0]        index,
    input  wire logic [15:0]        page,
    input  wire logic [6:0]         off7,
    input  wire logic [15:0]        off16,
    // Results
    output logic      [15:0]        ea,
    output logic                    wb_en,
    output logic      [15:0]        wb_val
);
    logic [15:0] step;

    always_comb begin
        step   = byte_op ? dag_pkg::STEP_BYTE : dag_pkg::STEP_WORD; // [RQ2] [RQ3]
        ea     = base;
        wb_en  = 1'b0;
        wb_val = base;
        case (mode)
            dag_pkg::M_INC: begin
                wb_en  = 1'b1;
                wb_val = base + step; // [RQ2] [RQ3]
            end
            dag_pkg::M_DEC: begin
                wb_en  = 1'b1;
                wb_val = base - step; // [RQ2]
            end
            dag_pkg::M_ADDX: begin
                wb_en  = 1'b1;
                wb_val = base + index; // [RQ22]
            end
            dag_pkg::M_IDXREL:  ea = base + index; // [RQ6]
            dag_pkg::M_PAGEREL: ea = page + {9'h000, off7}; // [RQ7]
            dag_pkg::M_LONGREL: ea = base + off16; // [RQ8]
            dag_pkg::M_DIRECT:  ea = off16; // [RQ18]
            default: ea = base;
        endcase
    end
endmodule : dag_agu
`default_nettype wire

// *** verilog/dag_ram.sv ***
`timescale 1ns/1ps
`default_nettype none
module dag_ram #(
    parameter int WORDS = dag_pkg::RAM_WORDS,
    parameter int AW    = dag_pkg::RAM_AW
) (
    // Clock
    input  wire logic          hclk,
    // Read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [16:0]   rd_data,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [16:0]   wr_data
);
    // Bit 16 of each word is its tag; the read is asynchronous so one command
    // can read, modify and write back a word within a single clock.
    logic [16:0] mem [WORDS]; // [RQ14]

    assign rd_data = mem[rd_addr];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : dag_ram
`default_nettype wire

// *** verilog/dag_top.sv ***
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: address registers hold byte addresses, halved
// RQ2: word post-increment adds two, decrement subtracts
// RQ3: byte post-increment advances by one
// RQ4: byte store writes low byte; even upper
// RQ5: port input stored; narrow port drops upper
// RQ6: index-relative adds index register, none modified
// RQ7: page-relative adds seven-bit offset to page
// RQ8: long-relative adds second word, base kept
// RQ9: flag ops touch only tag bit
// RQ10: field bit zero selects global word address
// RQ11: relative flag is page plus six bits
// RQ12: move flag to tag; logic back
// RQ13: flag tag set/clear take one cycle
// RQ14: data RAM is 640 words of 17
// RQ15: accumulator load copies tag into status
// RQ16: general tag ops use byte address, even
// RQ17: flag tag ops use word address
// RQ18: general tag ops take all modes
// RQ19: flag moves use word address
// RQ20: software keeps global flag address below 64
// RQ21: accumulator pointer modified before selection
// RQ22: post-add accesses then adds index register
// RQ23: post-modified register visible next instruction
module dag_top (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Port space
    input  wire logic [15:0] port_in,
    output logic      [15:0] port_out,
    output logic      [7:0]  port_num,
    output logic             port_strobe,
    // Accumulator selection
    output logic      [4:0]  accum_sel,
    output logic      [4:0]  accum_partner
);
    logic [15:0] areg_reg [8];
    logic [15:0] offset_reg;
    logic [15:0] src_reg;
    logic [16:0] result_reg;
    logic [4:0]  status_reg;
    logic [4:0]  ap_reg;
    logic [15:0] port_meta_reg;
    logic [15:0] port_sync_reg;
    logic [15:0] port_out_reg;
    logic [7:0]  port_num_reg;
    logic        port_strobe_reg;
    logic        dp_wr_reg;
    logic        dp_rd_reg;
    logic [7:0]  dp_addr_reg;

    dag_pkg::dag_op_t   c_op;
    dag_pkg::dag_mode_t c_mode;
    logic [2:0]  c_sel;
    logic [6:0]  c_fld;
    logic        c_byte;
    logic [1:0]  c_ap;
    logic        c_tf;
    logic [7:0]  c_port;
    logic        exec;
    logic        is_flag;
    logic        is_gen;
    logic [15:0] base;
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_val;
    logic [15:0] flag_wa;
    logic [15:0] wa;
    logic        in_range;
    logic [16:0] ram_rd;
    logic [16:0] rd;
    logic        we;
    logic [16:0] wdata;
    logic        tf_cur;
    logic [4:0]  ap_next;
    logic [15:0] load_val;

    // True when a bus byte offset falls on one of the address registers.
    function automatic logic areg_hit(input logic [7:0] a);
        areg_hit = (a <= dag_pkg::OFF_AREG7) && (a[1:0] == 2'h0);
    endfunction : areg_hit

    // Zero-wait slave: every transfer completes in its first data-phase cycle.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg   <= 1'b0;
            dp_rd_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else if (hready) begin
            dp_wr_reg   <= hsel && htrans[1] && hwrite;
            dp_rd_reg   <= hsel && htrans[1] && !hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (!dp_rd_reg) begin
            hrdata = 32'h0000_0000;
        end else if (areg_hit(dp_addr_reg)) begin
            hrdata = {16'h0000, areg_reg[dp_addr_reg[4:2]]};
        end else if (dp_addr_reg == dag_pkg::OFF_OFFSET) begin
            hrdata = {16'h0000, offset_reg};
        end else if (dp_addr_reg == dag_pkg::OFF_SRC) begin
            hrdata = {16'h0000, src_reg};
        end else if (dp_addr_reg == dag_pkg::OFF_RESULT) begin
            hrdata = {15'h0000, result_reg};
        end else if (dp_addr_reg == dag_pkg::OFF_STATUS) begin
            hrdata = {27'h0000000, status_reg};
        end else if (dp_addr_reg == dag_pkg::OFF_APTR) begin
            hrdata = {19'h00000, accum_partner, 3'h0, ap_reg};
        end
    end

    // Port pins come from outside the clock domain.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_meta_reg <= 16'h0000;
            port_sync_reg <= 16'h0000;
        end else begin
            port_meta_reg <= port_in;
            port_sync_reg <= port_meta_reg;
        end
    end

    // A command runs in the data phase of its own bus write.
    assign exec    = dp_wr_reg && (dp_addr_reg == dag_pkg::OFF_CMD); // [RQ13]
    assign c_op    = dag_pkg::dag_op_t'(hwdata[dag_pkg::CMD_OP_LSB +: 4]);
    assign c_mode  = dag_pkg::dag_mode_t'(hwdata[dag_pkg::CMD_MODE_LSB +: 3]);
    assign c_sel   = hwdata[dag_pkg::CMD_REG_LSB +: 3];
    assign c_fld   = hwdata[dag_pkg::CMD_FLD_LSB +: 7];
    assign c_byte  = hwdata[dag_pkg::CMD_BYTE_BIT];
    assign c_ap    = hwdata[dag_pkg::CMD_AP_LSB +: 2];
    assign c_tf    = hwdata[dag_pkg::CMD_TF_BIT];
    assign c_port  = hwdata[dag_pkg::CMD_PORT_LSB +: 8];
    assign is_flag = c_op >= dag_pkg::OP_FSET;
    assign is_gen  = (c_op != dag_pkg::OP_NOP) && !is_flag;
    assign base    = areg_reg[c_sel];
    assign tf_cur  = c_tf ? status_reg[dag_pkg::ST_TF2] : status_reg[dag_pkg::ST_TF1];

    dag_agu u_agu (
        .mode    (c_mode),
        .byte_op (c_byte),
        .base    (base),
        .index   (areg_reg[dag_pkg::IDX_REG]),
        .page    (areg_reg[dag_pkg::PAGE_REG]),
        .off7    (c_fld),
        .off16   (offset_reg),
        .ea      (ea),
        .wb_en   (wb_en),
        .wb_val  (wb_val)
    );

    // Global form can only name words below 64; higher tags need the page form.
    assign flag_wa = c_fld[0] ? areg_reg[dag_pkg::PAGE_REG] + {10'h000, c_fld[6:1]} // [RQ11]
                              : {10'h000, c_fld[6:1]}; // [RQ10] [RQ20]
    // Flag forms give a word address; all others a byte address whose low bit
    // only picks the byte, so an odd byte reaches its even word's tag.
    assign wa       = is_flag ? flag_wa : {1'b0, ea[15:1]}; // [RQ1] [RQ16] [RQ17] [RQ19]
    assign in_range = wa < 16'(dag_pkg::RAM_WORDS);
    assign rd       = in_range ? ram_rd : 17'h00000;

    always_comb begin
        we    = 1'b0;
        wdata = rd;
        case (c_op)
            dag_pkg::OP_STORE: begin
                we = 1'b1;
                if (!c_byte) begin
                    wdata = {rd[16], src_reg};
                end else if (ea[0]) begin
                    wdata = {rd[16:8], src_reg[7:0]}; // [RQ4]
                end else begin
                    wdata = {rd[16], src_reg[7:0], rd[7:0]}; // [RQ4]
                end
            end
            dag_pkg::OP_PIN: begin
                we    = 1'b1;
                wdata = {rd[16], port_sync_reg}; // [RQ5]
            end
            dag_pkg::OP_TSET, dag_pkg::OP_FSET: begin
                we    = 1'b1;
                wdata = {1'b1, rd[15:0]}; // [RQ9] [RQ18]
            end
            dag_pkg::OP_TCLR, dag_pkg::OP_FCLR: begin
                we    = 1'b1;
                wdata = {1'b0, rd[15:0]}; // [RQ9] [RQ18]
            end
            dag_pkg::OP_FMOV: begin
                we    = 1'b1;
                wdata = {tf_cur, rd[15:0]}; // [RQ12]
            end
            default: we = 1'b0;
        endcase
    end

    dag_ram #(
        .WORDS (dag_pkg::RAM_WORDS),
        .AW    (dag_pkg::RAM_AW)
    ) u_ram (
        .hclk    (hclk),
        .rd_addr (wa[dag_pkg::RAM_AW-1:0]),
        .rd_data (ram_rd),
        .we      (exec && we && in_range),
        .wr_addr (wa[dag_pkg::RAM_AW-1:0]),
        .wr_data (wdata)
    );

    // Address registers: bus writes, or the post-modify of a general command.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) begin
                areg_reg[i] <= dag_pkg::AREG_RST;
            end
        end else if (dp_wr_reg && areg_hit(dp_addr_reg)) begin
            areg_reg[dp_addr_reg[4:2]] <= hwdata[15:0];
        end else if (exec && is_gen && wb_en) begin
            areg_reg[c_sel] <= wb_val; // [RQ2] [RQ3] [RQ22] [RQ23]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offset_reg <= 16'h0000;
            src_reg    <= 16'h0000;
        end else if (dp_wr_reg && dp_addr_reg == dag_pkg::OFF_OFFSET) begin
            offset_reg <= hwdata[15:0];
        end else if (dp_wr_reg && dp_addr_reg == dag_pkg::OFF_SRC) begin
            src_reg <= hwdata[15:0];
        end
    end

    // Byte loads pick the upper half of the word for an even byte address.
    assign load_val = !c_byte ? rd[15:0] : (ea[0] ? {8'h00, rd[7:0]} : {8'h00, rd[15:8]});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_reg <= 17'h00000;
            status_reg <= dag_pkg::STATUS_RST;
        end else if (dp_wr_reg && dp_addr_reg == dag_pkg::OFF_STATUS) begin
            status_reg <= hwdata[4:0];
        end else if (exec && c_op == dag_pkg::OP_LOAD) begin
            result_reg                  <= {rd[16], load_val};
            status_reg[dag_pkg::ST_TAG]  <= rd[16]; // [RQ15]
            status_reg[dag_pkg::ST_ZERO] <= load_val == 16'h0000;
            status_reg[dag_pkg::ST_SIGN] <= load_val[15];
        end else if (exec && c_op >= dag_pkg::OP_FAND) begin
            if (c_tf) begin
                status_reg[dag_pkg::ST_TF2] <= c_op == dag_pkg::OP_FAND ? tf_cur & rd[16] :
                                              c_op == dag_pkg::OP_FOR  ? tf_cur | rd[16] :
                                                                         tf_cur ^ rd[16]; // [RQ12]
            end else begin
                status_reg[dag_pkg::ST_TF1] <= c_op == dag_pkg::OP_FAND ? tf_cur & rd[16] :
                                              c_op == dag_pkg::OP_FOR  ? tf_cur | rd[16] :
                                                                         tf_cur ^ rd[16]; // [RQ12]
            end
        end
    end

    // Pointer moves first; the selection outputs follow the new value.
    assign ap_next = c_ap == dag_pkg::AP_INC ? ap_reg + 5'h01 :
                     c_ap == dag_pkg::AP_DEC ? ap_reg - 5'h01 : ap_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_reg <= dag_pkg::AP_RST;
        end else if (dp_wr_reg && dp_addr_reg == dag_pkg::OFF_APTR) begin
            ap_reg <= hwdata[4:0];
        end else if (exec) begin
            ap_reg <= ap_next; // [RQ21]
        end
    end

    assign accum_sel     = ap_reg;
    assign accum_partner = ap_reg + dag_pkg::AP_PARTNER;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_out_reg    <= 16'h0000;
            port_num_reg    <= 8'h00;
            port_strobe_reg <= 1'b0;
        end else begin
            port_strobe_reg <= exec && c_op == dag_pkg::OP_POUT;
            if (exec && c_op == dag_pkg::OP_POUT) begin
                port_num_reg <= c_port;
                port_out_reg <= c_port == dag_pkg::NARROW_PORT ? {8'h00, rd[7:0]} : rd[15:0]; // [RQ5]
            end
        end
    end

    assign port_out    = port_out_reg;
    assign port_num    = port_num_reg;
    assign port_strobe = port_strobe_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_word_inc; // [RQ2]
        exec && is_gen && c_mode == dag_pkg::M_INC && !c_byte
            |=> areg_reg[$past(c_sel)] == $past(base) + 16'h0002;
    endproperty
    a_word_inc: assert property (p_word_inc) else $error("word post-increment wrong"); // [RQ2]

    property p_word_dec; // [RQ2]
        exec && is_gen && c_mode == dag_pkg::M_DEC && !c_byte
            |=> areg_reg[$past(c_sel)] == $past(base) - 16'h0002;
    endproperty
    a_word_dec: assert property (p_word_dec) else $error("word post-decrement wrong"); // [RQ2]

    property p_byte_inc; // [RQ3]
        exec && is_gen && c_mode == dag_pkg::M_INC && c_byte
            |=> areg_reg[$past(c_sel)] == $past(base) + 16'h0001;
    endproperty
    a_byte_inc: assert property (p_byte_inc) else $error("byte post-increment wrong"); // [RQ3]

    property p_idx_keep; // [RQ6]
        exec && is_gen && c_mode == dag_pkg::M_IDXREL
            |-> ea == base + areg_reg[dag_pkg::IDX_REG] ##1 $stable(areg_reg[dag_pkg::IDX_REG]);
    endproperty
    a_idx_keep: assert property (p_idx_keep) else $error("index-relative address wrong"); // [RQ6]

    property p_load_tag; // [RQ15]
        exec && c_op == dag_pkg::OP_LOAD && in_range
            |=> status_reg[dag_pkg::ST_TAG] == $past(ram_rd[16]);
    endproperty
    a_load_tag: assert property (p_load_tag) else $error("load did not copy tag"); // [RQ15]

    property p_flag_data; // [RQ9]
        exec && is_flag && we |-> wdata[15:0] == ram_rd[15:0];
    endproperty
    a_flag_data: assert property (p_flag_data) else $error("flag op changed data bits"); // [RQ9]

    property p_narrow; // [RQ5]
        exec && c_op == dag_pkg::OP_POUT && c_port == dag_pkg::NARROW_PORT
            |=> port_strobe && port_out[15:8] == 8'h00 && port_out[7:0] == $past(rd[7:0]);
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow port kept upper byte"); // [RQ5]

    property p_ap_inc; // [RQ21]
        exec && c_ap == dag_pkg::AP_INC |=> accum_sel == $past(ap_reg) + 5'h01;
    endproperty
    a_ap_inc: assert property (p_ap_inc) else $error("pointer not pre-incremented"); // [RQ21]

    property p_flag_word; // [RQ17]
        exec && is_flag && !c_fld[0] |-> wa == {10'h000, c_fld[6:1]};
    endproperty
    a_flag_word: assert property (p_flag_word) else $error("global flag word wrong"); // [RQ17]

    property p_tf_and; // [RQ12]
        exec && c_op == dag_pkg::OP_FAND && !c_tf
            |=> status_reg[dag_pkg::ST_TF1] == ($past(tf_cur) & $past(rd[16]));
    endproperty
    a_tf_and: assert property (p_tf_and) else $error("test flag AND wrong"); // [RQ12]

    c_postadd: cover property (exec && is_gen && c_mode == dag_pkg::M_ADDX);
    c_byte_st: cover property (exec && c_op == dag_pkg::OP_STORE && c_byte);
    c_rel_flg: cover property (exec && c_op == dag_pkg::OP_FSET && c_fld[0]);
endmodule : dag_top
`default_nettype wire

// *** tb/dag_port_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dag_port_model (
    // Clock
    input  wire logic        hclk,
    // Port space
    output logic      [15:0] port_in,
    input  wire logic [15:0] port_out,
    input  wire logic [7:0]  port_num,
    input  wire logic        port_strobe
);
    logic [15:0] val      = 16'h0;
    logic [15:0] last_out = 16'h0;
    logic [7:0]  last_num = 8'h0;

    // The pins hold a level; the block resynchronises it before use.
    assign port_in = val;

    // Latched mid-cycle so the capture never races the strobe's own edge.
    always @(negedge hclk) begin
        if (port_strobe === 1'b1) begin
            last_out <= port_out;
            last_num <= port_num;
        end
    end
endmodule : dag_port_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        port_strobe;
    logic [15:0] port_in;
    logic [15:0] port_out;
    logic [7:0]  port_num;
    logic [4:0]  accum_sel;
    logic [4:0]  accum_partner;
    int          failures   = 0;
    int          n_compared = 0;
    logic [16:0] mem [640];
    logic [15:0] ar [8];
    logic [15:0] offs, pexp;
    logic [16:0] res;
    logic [4:0]  st, ap;
    logic [31:0] rd;

    always #20 hclk = ~hclk;

    dag_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_in(port_in), .port_out(port_out),
        .port_num(port_num), .port_strobe(port_strobe), .accum_sel(accum_sel),
        .accum_partner(accum_partner));

    dag_port_model P (.hclk(hclk), .port_in(port_in), .port_out(port_out),
        .port_num(port_num), .port_strobe(port_strobe));

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // Read data is taken at the rising edge that ends the data phase.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            rd = hrdata;
        end while (hreadyout !== 1'b1);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0, d});
        if (a < 8'h20) ar[a[4:2]] = d;
        if (a == dag_pkg::OFF_OFFSET) offs = d;
        if (a == dag_pkg::OFF_STATUS) st = d[4:0];
        if (a == dag_pkg::OFF_APTR) ap = d[4:0];
    endtask : wr

    task automatic cmd(input int op, mode, rg, fld, byt = 0, tf = 0, pn = 0, apm = 0);
        logic [15:0] ba;
        logic [9:0]  w, fw;
        bus(1'b1, dag_pkg::OFF_CMD, {pn[7:0], 3'h0, tf[0], apm[1:0], byt[0], fld[6:0],
            rg[2:0], mode[2:0], op[3:0]});
        ap = ap + 5'(apm == 1) - 5'(apm == 2);
        ba = mode == 4 ? ar[rg] + ar[5] : mode == 5 ? ar[6] + fld[6:0] :
             mode == 6 ? ar[rg] + offs : mode == 7 ? offs : ar[rg];
        w  = ba[10:1];
        fw = fld[0] ? ar[6][9:0] + 10'(fld[6:1]) : 10'(fld[6:1]);
        case (op)
            1: begin
                res = mem[w];
                if (byt != 0) res[15:0] = {8'h0, mem[w][(ba[0] ? 0 : 8) +: 8]};
                st[0] = res[16];
                st[3] = res[15:0] == 16'h0;
                st[4] = res[15];
            end
            2: if (byt != 0) mem[w][(ba[0] ? 0 : 8) +: 8] = P.val[15:8];
               else mem[w][15:0] = {P.val[7:0], P.val[15:8]};
            3: mem[w][15:0] = P.val;
            4: pexp = (pn == 8) ? {8'h0, mem[w][7:0]} : mem[w][15:0];
            5, 6: mem[w][16] = (op == 5);
            7, 8: mem[fw][16] = (op == 7);
            9: mem[fw][16] = st[1 + tf];
            10: st[1 + tf] &= mem[fw][16];
            11: st[1 + tf] |= mem[fw][16];
            12: st[1 + tf] ^= mem[fw][16];
            default: ;
        endcase
        if (op >= 1 && op <= 6 && mode >= 1 && mode <= 3) begin
            ar[rg] = mode == 1 ? ar[rg] + (byt != 0 ? 1 : 2) :
                     mode == 2 ? ar[rg] - (byt != 0 ? 1 : 2) : ar[rg] + ar[5];
        end
    endtask : cmd

    // Store data is derived from the port pins; the source register gets the same value with its two bytes swapped.
    task automatic setsrc(input logic [15:0] v);
        P.val <= v;
        @(posedge hclk);
        bus(1'b1, dag_pkg::OFF_SRC, {16'h0, v[7:0], v[15:8]});
    endtask : setsrc

    task automatic ldc(input int mode, rg, fld, byt = 0);
        cmd(1, mode, rg, fld, byt);
        bus(1'b0, dag_pkg::OFF_RESULT, 32'h0);
        chk("result", rd, {15'h0, res});
    endtask : ldc

    task automatic verify;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk("areg", rd, {16'h0, ar[i]});
        end
        bus(1'b0, dag_pkg::OFF_STATUS, 32'h0);
        chk("status", rd, {27'h0, st});
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b0, dag_pkg::OFF_APTR, 32'h0);
        chk("aptr", rd, {19'h0, ap + 5'h10, 3'h0, ap});
        chk("accum", {22'h0, accum_partner, accum_sel}, {22'h0, ap + 5'h10, ap});
    endtask : verify

    task automatic dump;
        for (int i = 0; i < 32; i++) begin
            wr(dag_pkg::OFF_OFFSET, 16'(2 * i));
            ldc(7, 0, 0);
        end
    endtask : dump

    initial begin
        #(40 * 20000);
        failures++;
        wrap_up();
    end

    initial begin
        rd = $urandom(9);
        st = 5'h0;
        ap = 5'h0;
        offs = 16'h0;
        for (int i = 0; i < 8; i++) ar[i] = 16'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        verify;
        // Words 0..31 get random data and a cleared tag; flag addresses stay below 64.
        for (int i = 0; i < 32; i++) begin
            setsrc(16'($urandom));
            cmd(2, 1, 0, 0);
            cmd(8, 0, 0, 2 * i);
        end
        verify;
        dump;
        $display("test fill done");
        wr(8'h04, 16'h10);
        ldc(0, 1, 0);
        ldc(2, 1, 0);
        wr(8'h14, 16'h04);
        wr(8'h0c, 16'h0c);
        ldc(4, 3, 0);
        wr(8'h18, 16'h08);
        ldc(5, 0, 8);
        wr(8'h1c, 16'h04);
        wr(dag_pkg::OFF_OFFSET, 16'h0c);
        ldc(6, 7, 0);
        wr(8'h10, 16'h10);
        ldc(3, 4, 0);
        verify;
        $display("test modes done");
        wr(8'h08, 16'h21);
        setsrc(16'($urandom));
        cmd(2, 1, 2, 0, 1);
        wr(8'h08, 16'h20);
        setsrc(16'($urandom));
        cmd(2, 1, 2, 0, 1);
        ldc(2, 2, 0, 1);
        ldc(0, 2, 0, 1);
        verify;
        wr(dag_pkg::OFF_OFFSET, 16'h21);
        for (int m = 0; m < 8; m++) cmd(5 + (m % 2), m, 3, 8);
        cmd(5, 7, 0, 0);
        verify;
        dump;
        $display("test bytes and tags done");
        wr(dag_pkg::OFF_STATUS, 16'h02);
        cmd(9, 0, 0, 10);
        cmd(9, 0, 0, 7, 0, 1);
        for (int op = 10; op < 13; op++) begin
            for (int f = 0; f < 4; f++) cmd(op, 0, 0, (f < 2) ? 10 : 7, 0, f % 2);
        end
        verify;
        dump;
        $display("test flags done");
        wr(dag_pkg::OFF_APTR, 16'h1f);
        cmd(0, 0, 0, 0, 0, 0, 0, 1);
        verify;
        cmd(0, 0, 0, 0, 0, 0, 0, 2);
        verify;
        $display("test pointer done");
        wr(8'h04, 16'h20);
        for (int k = 0; k < 2; k++) begin
            cmd(4, 2, 1, 0, 0, 0, k ? 3 : 8);
            bus(1'b0, dag_pkg::OFF_RESULT, 32'h0);
            chk("port_out", {16'h0, P.last_out}, {16'h0, pexp});
            chk("port_num", {24'h0, P.last_num}, k ? 32'h3 : 32'h8);
        end
        P.val <= 16'($urandom);
        repeat (3) @(posedge hclk);
        cmd(3, 1, 1, 0);
        verify;
        dump;
        bus(1'b1, 8'h40, 32'h1234);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test ports done");
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
